// >>> src/ctp_clk_if.sv
// source clock selection link between timer core and prescaler
`timescale 1ns/1ps
`default_nettype none

interface ctp_clk_if;
  import ctp_pkg::*;
  logic [2:0] sel;      // source clock select code
  logic       slow;     // slow or sleep power mode
  logic       div_sel;  // divider clock select
  ctp_mode_t  mode;     // limits the legal choices
  logic       tick;     // one-cycle source clock event

  modport timer (output sel, output slow, output div_sel, output mode,
                 input tick);
  modport pscl  (input sel, input slow, input div_sel, input mode,
                 output tick);
endinterface

`default_nettype wire

// >>> src/ctp_pkg.sv
// constants and types shared by the cascadable timer block
package ctp_pkg;

  // ---------------------------------------------------------------
  // source clock select codes
  // ---------------------------------------------------------------
  localparam logic [2:0] CTP_SEL_DIV11 = 3'h0; // fc/2^11, or fs/2^3
  localparam logic [2:0] CTP_SEL_DIV7  = 3'h1; // fc/2^7
  localparam logic [2:0] CTP_SEL_DIV5  = 3'h2; // fc/2^5
  localparam logic [2:0] CTP_SEL_DIV3  = 3'h3; // fc/2^3
  localparam logic [2:0] CTP_SEL_FS    = 3'h4; // low freq clock
  localparam logic [2:0] CTP_SEL_DIV1  = 3'h5; // fc/2
  localparam logic [2:0] CTP_SEL_FC    = 3'h6; // fc

  // ---------------------------------------------------------------
  // divider tap positions and widths
  // ---------------------------------------------------------------
  localparam int CTP_PRE_W    = 11;  // high freq prescaler width
  localparam int CTP_FS_PRE_W = 3;   // low freq prescaler width
  localparam int CTP_TAP_11   = 11;
  localparam int CTP_TAP_7    = 7;
  localparam int CTP_TAP_5    = 5;
  localparam int CTP_TAP_3    = 3;
  localparam int CTP_TAP_1    = 1;

  // ---------------------------------------------------------------
  // counter layout and reset values
  // ---------------------------------------------------------------
  localparam int          CTP_CNT_W      = 16;
  localparam logic [7:0]  CTP_PWM_TOP    = 8'hff; // 8-bit wrap point
  localparam logic [7:0]  CTP_PW_RST     = 8'h00;
  localparam logic [15:0] CTP_PERIOD_RST = 16'h0000;
  localparam logic [15:0] CTP_CNT_RST    = 16'h0000;
  localparam logic        CTP_FF_RST     = 1'b0;

  // operating mode of the pair
  typedef enum logic {CTP_MODE_PWM8, CTP_MODE_TIMER16} ctp_mode_t;

endpackage

// >>> src/ctp_prescaler.sv
// source clock prescaler: divided high and low freq tick select
`timescale 1ns/1ps
`default_nettype none

module ctp_prescaler
  import ctp_pkg::*;
(
  input  wire logic clk_sys_in,
  input  wire logic rst_n_in,
  input  wire logic fs_clk_in,   // raw low freq clock from its pin
  ctp_clk_if.pscl   clk_if
);

  logic [CTP_PRE_W-1:0]    pre_ff;
  logic [CTP_PRE_W-1:0]    nxt_pre;
  logic [CTP_FS_PRE_W-1:0] fs_pre_ff;
  logic                    fs_meta_ff;
  logic                    fs_sync_ff;
  logic                    fs_last_ff;
  logic                    fs_rise;
  logic                    fs_div3;
  logic                    tick_fast;
  logic                    tick_slow;

  // ---------------------------------------------------------------
  // tap decode: a tap ticks when all its lower bits roll over
  // ---------------------------------------------------------------
  function automatic logic tap_roll(input logic [CTP_PRE_W-1:0] v,
                                    input int n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < CTP_PRE_W; i++)
    begin
      if (i < n)
      begin
        r = r & v[i];
      end
    end
    return r;
  endfunction

  assign nxt_pre = pre_ff + {{(CTP_PRE_W-1){1'b0}}, 1'b1};
  assign fs_rise = fs_sync_ff & ~fs_last_ff;
  assign fs_div3 = fs_rise & (&fs_pre_ff);

  // normal/idle choices; slow/sleep offers only the fs sources
  assign tick_fast =
    (clk_if.sel == CTP_SEL_DIV11) ?
      (clk_if.div_sel ? fs_div3 : tap_roll(pre_ff, CTP_TAP_11)) :
    (clk_if.sel == CTP_SEL_DIV7)  ? tap_roll(pre_ff, CTP_TAP_7) :
    (clk_if.sel == CTP_SEL_DIV5)  ? tap_roll(pre_ff, CTP_TAP_5) :
    (clk_if.sel == CTP_SEL_DIV3)  ? tap_roll(pre_ff, CTP_TAP_3) :
    (clk_if.sel == CTP_SEL_FS)    ? fs_rise :
    (clk_if.sel == CTP_SEL_DIV1)  ? tap_roll(pre_ff, CTP_TAP_1) :
    (clk_if.sel == CTP_SEL_FC)    ? 1'b1 : 1'b0;              // see [RL13]
  assign tick_slow =
    (clk_if.sel == CTP_SEL_DIV11) ? fs_div3 :
    (clk_if.sel == CTP_SEL_FS)    ? fs_rise : 1'b0;           // see [RL13]

  // ---------------------------------------------------------------
  // prescalers and low freq synchroniser
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      pre_ff     <= '0;
      fs_pre_ff  <= '0;
      fs_meta_ff <= 1'b0;
      fs_sync_ff <= 1'b0;
      fs_last_ff <= 1'b0;
    end
    else
    begin
      pre_ff     <= nxt_pre;
      fs_meta_ff <= fs_clk_in;
      fs_sync_ff <= fs_meta_ff;
      fs_last_ff <= fs_sync_ff;
      if (fs_rise)
      begin
        fs_pre_ff <= fs_pre_ff + {{(CTP_FS_PRE_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // timer mode only accepts the four divided sources
  always_comb
  begin
    if (clk_if.mode == CTP_MODE_TIMER16 && clk_if.sel > CTP_SEL_DIV3)
    begin
      clk_if.tick = 1'b0;                                     // see [RL20]
    end
    else if (clk_if.slow)
    begin
      clk_if.tick = tick_slow;
    end
    else
    begin
      clk_if.tick = tick_fast;
    end
  end

endmodule

`default_nettype wire

// >>> src/ctp_timer.sv
// cascadable timer pair: 8-bit pwm and 16-bit timer modes
//
// Summary of operation
// [RL1] pwm mode counts source clock; match with width inverts output flop
// [RL2] pwm overflow inverts flop again, clears counter, raises interrupt
// [RL3] flop start level loads from initial-value bit; reset clears it
// [RL4] pwm pin always drives inverse of the output flop
// [RL5] width written while running waits in shift stage until interrupt
// [RL6] width written while stopped becomes active straight away
// [RL7] width read returns the active value, not the pending one
// [RL8] software rewrites width right after interrupt, never coinciding
// [RL9] stopping the timer holds the pwm pin level
// [RL10] software changes initial-value bit only after the timer stopped
// [RL11] clear run bit, then clear initial-value bit drives pin high
// [RL12] software stops timer before entering stop power mode
// [RL13] pwm source is one of seven clocks; slow modes offer two
// [RL14] software sets the port output latch of the pwm pin to 1
// [RL15] timer mode cascades both counters into one 16-bit counter
// [RL16] once running, 16-bit match raises interrupt, clears, keeps counting
// [RL17] software writes period low byte then high byte, never one alone
// [RL18] software keeps initial-value bit at 0 in timer mode
// [RL19] timer mode period register is unbuffered, write acts at once
// [RL20] timer mode source limited to the four divided clocks
// [RL21] 8-bit pwm counter wraps 255 to 0, period 256 source clocks
`timescale 1ns/1ps
`default_nettype none

module ctp_timer
  import ctp_pkg::*;
(
  input  wire logic        CLK_SYS_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        MODE_TIMER16_IN, // 0 = 8-bit pwm
  input  wire logic [2:0]  CLK_SEL_IN,
  input  wire logic        DIV_CLK_SEL_IN,  // divider clock select
  input  wire logic        SLOW_MODE_IN,    // slow or sleep power mode
  input  wire logic        LOW_FREQ_CLK_IN, // raw low freq clock pin
  input  wire logic        RUN_IN,          // timer run bit
  input  wire logic        FF_INIT_IN,      // flop initial-value bit
  input  wire logic        PW_WR_IN,
  input  wire logic [7:0]  PW_DATA_IN,
  input  wire logic        PERIOD_LO_WR_IN,
  input  wire logic        PERIOD_HI_WR_IN,
  input  wire logic [7:0]  PERIOD_DATA_IN,
  output logic      [7:0]  PW_RD_DATA_OUT,
  output logic      [15:0] PERIOD_RD_DATA_OUT,
  output logic      [15:0] COUNT_OUT,
  output logic             PWM_PIN_OUT,
  output logic             TIMER_IRQ_OUT
);

  ctp_clk_if clk_if ();

  logic [CTP_CNT_W-1:0] cnt_ff;
  logic [CTP_CNT_W-1:0] nxt_cnt;
  logic [CTP_CNT_W-1:0] cnt_inc;
  logic [7:0]           pw_shift_ff;
  logic [7:0]           pw_active_ff;
  logic [7:0]           nxt_pw_active;
  logic [15:0]          period_ff;
  logic                 out_ff;
  logic                 nxt_out;
  logic                 init_last_ff;
  logic                 pin_ff;
  logic                 irq_ff;
  logic                 tick;
  logic                 pwm_mode;
  logic                 pwm_ovf;
  logic                 pwm_match;
  logic                 tmr_match;
  logic                 irq_ev;
  logic                 init_chg;

  // ---------------------------------------------------------------
  // source clock prescaler
  // ---------------------------------------------------------------
  assign clk_if.sel     = CLK_SEL_IN;
  assign clk_if.slow    = SLOW_MODE_IN;
  assign clk_if.div_sel = DIV_CLK_SEL_IN;
  assign clk_if.mode    = MODE_TIMER16_IN ? CTP_MODE_TIMER16
                                          : CTP_MODE_PWM8;

  ctp_prescaler u_pscl (
    .clk_sys_in (CLK_SYS_IN),
    .rst_n_in   (RST_N_IN),
    .fs_clk_in  (LOW_FREQ_CLK_IN),
    .clk_if     (clk_if.pscl)
  );

  // ---------------------------------------------------------------
  // count events
  // ---------------------------------------------------------------
  assign tick      = RUN_IN & clk_if.tick;
  assign pwm_mode  = (clk_if.mode == CTP_MODE_PWM8);
  assign cnt_inc   = cnt_ff + {{(CTP_CNT_W-1){1'b0}}, 1'b1};
  assign pwm_ovf   = tick & pwm_mode
                   & (cnt_ff[7:0] == CTP_PWM_TOP);           // see [RL21]
  assign pwm_match = tick & pwm_mode & ~pwm_ovf
                   & (cnt_inc[7:0] == pw_active_ff);         // see [RL1]
  assign tmr_match = tick & ~pwm_mode
                   & (cnt_inc == period_ff);                 // see [RL16]
  assign irq_ev    = pwm_ovf | tmr_match;                    // see [RL2]
  assign init_chg  = ~RUN_IN & (FF_INIT_IN != init_last_ff);

  // next counter: pwm uses the low byte, timer the cascaded pair
  always_comb
  begin
    nxt_cnt = cnt_ff;
    if (!RUN_IN)
    begin
      nxt_cnt = CTP_CNT_RST;
    end
    else if (irq_ev)
    begin
      nxt_cnt = CTP_CNT_RST;                          // see [RL2] see [RL16]
    end
    else if (tick && pwm_mode)
    begin
      nxt_cnt = {8'h00, cnt_inc[7:0]};                        // see [RL1]
    end
    else if (tick)
    begin
      nxt_cnt = cnt_inc;                                      // see [RL15]
    end
  end

  // output flop: toggles on match and overflow; when stopped, holds unless the initial-value bit changes, then loads it
  always_comb
  begin
    nxt_out = out_ff;
    if (init_chg)
    begin
      nxt_out = FF_INIT_IN;                          // see [RL3] see [RL11]
    end
    else if (pwm_match || pwm_ovf)
    begin
      nxt_out = ~out_ff;                              // see [RL1] see [RL2]
    end
  end

  // active width: immediate when stopped, at interrupt when running
  always_comb
  begin
    nxt_pw_active = pw_active_ff;
    if (PW_WR_IN && !RUN_IN)
    begin
      nxt_pw_active = PW_DATA_IN;                             // see [RL6]
    end
    else if (pwm_ovf)
    begin
      nxt_pw_active = pw_shift_ff;                            // see [RL5]
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // counter, output flop, pin and interrupt pulse
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      cnt_ff       <= CTP_CNT_RST;
      out_ff       <= CTP_FF_RST;                             // see [RL3]
      init_last_ff <= CTP_FF_RST;
      pin_ff       <= ~CTP_FF_RST;
      irq_ff       <= 1'b0;
    end
    else
    begin
      cnt_ff       <= nxt_cnt;
      out_ff       <= nxt_out;                                // see [RL9]
      init_last_ff <= FF_INIT_IN;
      pin_ff       <= ~nxt_out;                               // see [RL4]
      irq_ff       <= irq_ev;
    end
  end

  // width shift stage and active compare value
  // a write in the overflow cycle lands in the shift stage only
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      pw_shift_ff  <= CTP_PW_RST;
      pw_active_ff <= CTP_PW_RST;
    end
    else
    begin
      pw_active_ff <= nxt_pw_active;
      if (PW_WR_IN)
      begin
        pw_shift_ff <= PW_DATA_IN;                            // see [RL5]
      end
    end
  end

  // period compare: no shadow stage, a byte write acts at once
  // a lone byte write leaves the other half as it was
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (!RST_N_IN)
    begin
      period_ff <= CTP_PERIOD_RST;
    end
    else
    begin
      if (PERIOD_LO_WR_IN)
      begin
        period_ff[7:0] <= PERIOD_DATA_IN;                     // see [RL19]
      end
      if (PERIOD_HI_WR_IN)
      begin
        period_ff[15:8] <= PERIOD_DATA_IN;                    // see [RL19]
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs, all straight from flops
  // ---------------------------------------------------------------
  assign PW_RD_DATA_OUT     = pw_active_ff;                   // see [RL7]
  assign PERIOD_RD_DATA_OUT = period_ff;
  assign COUNT_OUT          = cnt_ff;
  assign PWM_PIN_OUT        = pin_ff;
  assign TIMER_IRQ_OUT      = irq_ff;

endmodule

`default_nettype wire

// >>> verification/ctp_timer_sva.sv
// assertion checker for the cascadable timer pair
`timescale 1ns/1ps
`default_nettype none

module ctp_timer_chk (
  input wire logic        CLK_SYS_IN,
  input wire logic        RST_N_IN,
  input wire logic        MODE_TIMER16_IN,
  input wire logic        RUN_IN,
  input wire logic        FF_INIT_IN,
  input wire logic        PW_WR_IN,
  input wire logic [7:0]  PW_DATA_IN,
  input wire logic [7:0]  PW_RD_DATA_OUT,
  input wire logic [15:0] PERIOD_RD_DATA_OUT,
  input wire logic [15:0] COUNT_OUT,
  input wire logic        PWM_PIN_OUT,
  input wire logic        TIMER_IRQ_OUT
);
  // ----------------------------------------------------------
  // timing properties
  // ----------------------------------------------------------
  default clocking cb_sys @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RST_N_IN);
  wire logic pwm_m = !MODE_TIMER16_IN;

  irq_pulse_a: assert property (TIMER_IRQ_OUT |=> !TIMER_IRQ_OUT)
    else $error("irq wider than one cycle");
  ovf_toggle_a: assert property (pwm_m && TIMER_IRQ_OUT |->
    PWM_PIN_OUT != $past(PWM_PIN_OUT)) else $error("no toggle at wrap");
  ovf_wrap_a: assert property (pwm_m && TIMER_IRQ_OUT |->
    $past(COUNT_OUT) == 16'h00ff) else $error("wrap not from 255");
  match_tog_a: assert property (pwm_m && RUN_IN &&
    $changed(COUNT_OUT) && COUNT_OUT != 16'h0000 &&
    COUNT_OUT[7:0] == PW_RD_DATA_OUT |-> PWM_PIN_OUT != $past(PWM_PIN_OUT))
    else $error("no toggle at width match");
  period_hit_a: assert property (MODE_TIMER16_IN &&
    TIMER_IRQ_OUT |-> $past(COUNT_OUT) == PERIOD_RD_DATA_OUT - 16'h0001)
    else $error("timer irq off period");
  stop_clear_a: assert property (!RUN_IN |=>
    COUNT_OUT == 16'h0000 && !TIMER_IRQ_OUT) else $error("count while off");
  stop_hold_a: assert property (
    (!RUN_IN && $stable(FF_INIT_IN)) [*3] |-> $stable(PWM_PIN_OUT))
    else $error("pin moved while stopped");
  ff_load_a: assert property (!RUN_IN && !$past(RUN_IN) &&
    $changed(FF_INIT_IN) |-> ##[1:2] PWM_PIN_OUT != FF_INIT_IN)
    else $error("init level not loaded");
  pw_idle_wr_a: assert property (!RUN_IN && PW_WR_IN |=>
    PW_RD_DATA_OUT == $past(PW_DATA_IN)) else $error("idle width lost");

  // main scenarios reached
  cover property (pwm_m && TIMER_IRQ_OUT);
  cover property (MODE_TIMER16_IN && TIMER_IRQ_OUT);
  cover property (!RUN_IN && $changed(FF_INIT_IN));
endmodule

`default_nettype wire

// >>> verification/test_ctp_timer.sv
// self-checking bench for the cascadable timer pair
`timescale 1ns/1ps
`default_nettype none

module test_ctp_timer;
  import ctp_pkg::*;
  // ----------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------
  logic        clk = 1'b0, rst_n = 1'b0, mode = 1'b0, dsel = 1'b0;
  logic        slow = 1'b0, lfc = 1'b0, run = 1'b0, ffi = 1'b0;
  logic        pw_wr = 1'b0, lo_wr = 1'b0, hi_wr = 1'b0, pin, irq;
  logic [2:0]  sel = CTP_SEL_FC;
  logic [7:0]  pw_d = 8'h00, per_d = 8'h00, pw_rd;
  logic [15:0] per_rd, cnt;
  int          error_cnt = 0, cmp_count = 0, n;
  // pad level behind the port output latch, kept at 1 by software
  logic        port_latch = 1'b1;
  wire logic   pad = pin & port_latch;
  // {mode, slow, dsel, sel} and expected tick spacing, 3000 = none
  logic [5:0]  cfg [14] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05,
    6'h06, 6'h08, 6'h10, 6'h11, 6'h14, 6'h23, 6'h26, 6'h25};
  int          gap_exp [14] = '{2048, 128, 32, 8, 20, 2, 1, 160, 160,
    3000, 20, 8, 3000, 3000};

  always #5 clk = ~clk;
  // low freq clock, 20 system cycles a period
  always #100 lfc = ~lfc;

  ctp_timer u_ctp_timer (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
    .MODE_TIMER16_IN(mode), .CLK_SEL_IN(sel), .DIV_CLK_SEL_IN(dsel),
    .SLOW_MODE_IN(slow), .LOW_FREQ_CLK_IN(lfc), .RUN_IN(run),
    .FF_INIT_IN(ffi), .PW_WR_IN(pw_wr), .PW_DATA_IN(pw_d),
    .PERIOD_LO_WR_IN(lo_wr), .PERIOD_HI_WR_IN(hi_wr),
    .PERIOD_DATA_IN(per_d), .PW_RD_DATA_OUT(pw_rd),
    .PERIOD_RD_DATA_OUT(per_rd), .COUNT_OUT(cnt), .PWM_PIN_OUT(pin),
    .TIMER_IRQ_OUT(irq));

  // ----------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [15:0] seen, exp, input string msg);
    cmp_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  // wait for irq, or for a count value, bounded
  task automatic wt(input logic on_irq, input logic [15:0] v, output int k);
    k = 0;
    while (!(on_irq ? irq === 1'b1 : cnt === v) && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
    if (k >= 3000)
    begin
      error_cnt++;
      $display("BAD %0t wait ran out", $time);
    end
  endtask
  // cycles until the count next moves
  task automatic gap(output int k);
    logic [15:0] c;
    c = cnt;
    k = 0;
    while (cnt === c && k < 3000)
    begin
      @(negedge clk);
      k++;
    end
  endtask
  task automatic wr_pw(input logic [7:0] d);
    @(posedge clk);
    pw_wr <= 1'b1;
    pw_d <= d;
    @(posedge clk);
    pw_wr <= 1'b0;
  endtask
  // period bytes go low first, then high
  task automatic wr_per(input logic [15:0] d);
    @(posedge clk);
    lo_wr <= 1'b1;
    per_d <= d[7:0];
    @(posedge clk);
    lo_wr <= 1'b0;
    hi_wr <= 1'b1;
    per_d <= d[15:8];
    @(posedge clk);
    hi_wr <= 1'b0;
  endtask
  task automatic set_run(input logic r, input logic f);
    @(posedge clk);
    run <= r;
    ffi <= f;
    cyc(3);
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    chk(16'(pad), 16'h0001, "pad after reset");
    wr_pw(8'h10);
    cyc(1);
    chk(16'(pw_rd), 16'h0010, "idle width write");
    set_run(1'b1, 1'b0);
    wt(1'b1, 16'h0000, n);
    chk(cnt, 16'h0000, "count at wrap");
    chk(16'(pin), 16'h0001, "pin at wrap");
    wt(1'b0, 16'h0010, n);
    chk(16'(pin), 16'h0000, "pin at match");
    wr_pw(8'h80);
    cyc(1);
    chk(16'(pw_rd), 16'h0010, "pending width read");
    wt(1'b1, 16'h0000, n);
    chk(16'(pw_rd), 16'h0080, "width after wrap");
    cyc(1);
    wt(1'b1, 16'h0000, n);
    chk(16'(n + 1), 16'h0100, "pwm period");
    wt(1'b0, 16'h0090, n);
    set_run(1'b0, 1'b0);
    chk(16'(pin), 16'h0000, "pin held at stop");
    set_run(1'b0, 1'b1);
    set_run(1'b0, 1'b0);
    chk(16'(pin), 16'h0001, "pin forced high");
    set_run(1'b0, 1'b1);
    chk(16'(pin), 16'h0000, "pin from high init");
    set_run(1'b1, 1'b1);
    wt(1'b0, 16'h0080, n);
    chk(16'(pin), 16'h0001, "inverted pulse");
    set_run(1'b0, 1'b1);
    set_run(1'b0, 1'b0);
    // count must sit at 0 before each new source starts
    for (int i = 0; i < 14; i++)
    begin
      @(posedge clk);
      {mode, slow, dsel, sel} <= cfg[i];
      run <= 1'b1;
      gap(n);
      gap(n);
      chk(16'(n), 16'(gap_exp[i]), "tick spacing");
      @(posedge clk);
      run <= 1'b0;
      cyc(2);
    end
    @(posedge clk);
    {mode, slow, dsel, sel} <= {3'b100, CTP_SEL_DIV3};
    wr_per(16'h0102);
    cyc(1);
    chk(per_rd, 16'h0102, "period readback");
    set_run(1'b1, 1'b0);
    wt(1'b1, 16'h0000, n);
    cyc(1);
    wt(1'b1, 16'h0000, n);
    chk(16'(n + 1), 16'h0810, "timer interval");
    complete_run();
  end

  // hang guard, well beyond the expected run length
  initial
  begin
    #1000000;
    error_cnt++;
    complete_run();
  end
endmodule

bind ctp_timer ctp_timer_chk u_ctp_timer_chk (.CLK_SYS_IN(CLK_SYS_IN),
  .RST_N_IN(RST_N_IN), .MODE_TIMER16_IN(MODE_TIMER16_IN), .RUN_IN(RUN_IN),
  .FF_INIT_IN(FF_INIT_IN), .PW_WR_IN(PW_WR_IN), .PW_DATA_IN(PW_DATA_IN),
  .PW_RD_DATA_OUT(PW_RD_DATA_OUT), .PERIOD_RD_DATA_OUT(PERIOD_RD_DATA_OUT),
  .COUNT_OUT(COUNT_OUT), .PWM_PIN_OUT(PWM_PIN_OUT),
  .TIMER_IRQ_OUT(TIMER_IRQ_OUT));

`default_nettype wire
